// [tdm_error_injector.sv]
// Tributary error injector with Wishbone register access
`timescale 1ns/100ps
module tdm_error_injector
  import tdm_error_injector_pkg::*;
#(
  parameter int SECOND_CYCLES = CLK_HZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Framer side
  input  wire logic        burst_i,
  input  wire logic        ds3_muxed_i,
  input  wire logic        loop_up_detected_i,
  input  wire logic        loop_down_detected_i,
  input  wire logic        ds1_tick_i,
  input  wire logic [3:0]  ds1_slot_i,
  input  wire logic        ds2_tick_i,
  input  wire logic [3:0]  ds2_slot_i,
  input  wire logic        ds3a_tick_i,
  input  wire logic [3:0]  ds3a_slot_i,
  input  wire logic        second_ds3_channel_tick_i,
  input  wire logic [3:0]  second_ds3_channel_slot_i,
  input  wire logic        e1_tick_i,
  input  wire logic [3:0]  e1_slot_i,
  input  wire logic        vt_tick_i,
  input  wire logic [3:0]  vt_slot_i,
  output logic             ds1_err_o,
  output logic             ds2_err_o,
  output logic             ds3a_err_o,
  output logic             second_ds3_channel_err_o,
  output logic             e1_err_o,
  output logic             vt_err_o,
  output logic [3:0]       ds1_err_type_o,
  output logic [3:0]       ds2_err_type_o,
  output logic [3:0]       ds3a_err_type_o,
  output logic [3:0]       second_ds3_channel_err_type_o,
  output logic [3:0]       e1_err_type_o,
  output logic [3:0]       vt_err_type_o,
  output logic             loop_activate_code_send_o,
  output logic             loop_release_code_send_o,
  output logic [11:0]      tx_up_code_o,
  output logic [11:0]      tx_dn_code_o,
  output logic [11:0]      rx_up_code_o,
  output logic [11:0]      rx_dn_code_o,
  output logic [5:0]       outband_up_code_o,
  output logic [5:0]       outband_dn_code_o
);

  //----------------------------------------------------------------------------
  // Functions
  //----------------------------------------------------------------------------

  function automatic logic is_steady(input logic [3:0] rate);
    return (rate >= RT_E2) && (rate <= RT_E9);
  endfunction : is_steady

  // Bits between errors minus one; a table keeps the decade counts in one place
  function automatic logic [29:0] rate_period(input logic [3:0] rate);
    logic [3:0] idx;
    idx = rate - RT_E2;
    return is_steady(rate) ? RATE_PERIOD[idx[2:0]] : 30'h0;
  endfunction : rate_period

  // Error types each channel offers
  function automatic logic type_ok(input int ch, input logic [3:0] t);
    logic ok;
    ok = 1'b0;
    unique case (ch)
      CH_DS1:  ok = (t == ET_BPV) || (t == ET_DATA) || (t == ET_DATA_CHECK)
                    || (t == ET_FRAME);
      CH_DS2:  ok = (t >= ET_C1) && (t <= ET_C_ALL);
      CH_DS3A,
      CH_SECOND_DS3_CHANNEL: ok = (t <= ET_C_ALL);
      CH_E1:   ok = (t == ET_BPV) || (t == ET_DATA) || (t == ET_DATA_CHECK)
                    || (t == ET_FRAME_CHECK) || (t == ET_MFRAME_CHECK);
      default: ok = (t == ET_LOGIC) || (t == ET_REI) || (t == ET_FEBE)
                    || (t == ET_POINTER);
    endcase
    return ok;
  endfunction : type_ok

  // Rates each error type accepts
  function automatic logic rate_ok(input logic [3:0] t, input logic [3:0] r);
    logic ok;
    ok = 1'b0;
    if (t == ET_POINTER) begin
      ok = (r == RT_OFF) || ((r >= RT_CONS7) && (r <= RT_CONT));
    end else if (t == ET_REI) begin
      ok = (r == RT_OFF) || (r == RT_SINGLE) || ((r >= RT_E2) && (r <= RT_E4));
    end else if (t == ET_FEBE) begin
      ok = (r == RT_OFF) || (r == RT_SINGLE) || ((r >= RT_E2) && (r <= RT_E8));
    end else begin
      ok = (r <= RT_E9);
    end
    return ok;
  endfunction : rate_ok

  // Whether the current bit may carry the chosen error type
  function automatic logic slot_match(input logic [3:0] t, input logic [3:0] s);
    logic m;
    m = 1'b0;
    unique case (t)
      ET_BPV:          m = 1'b1;
      ET_FRAME,
      ET_FRAME_CHECK:  m = (s == SL_FRAME);
      ET_PARITY:       m = (s == SL_PARITY);
      ET_C1:           m = (s == SL_C1);
      ET_C2:           m = (s == SL_C2);
      ET_C3:           m = (s == SL_C3);
      ET_C_ALL:        m = (s >= SL_C1) && (s <= SL_C3);
      ET_MFRAME_CHECK: m = (s == SL_MFRAME);
      ET_REI,
      ET_FEBE:         m = (s == SL_CHECK);
      ET_POINTER:      m = (s == SL_POINTER);
      default:         m = (s == SL_PAYLOAD);
    endcase
    return m;
  endfunction : slot_match

  //----------------------------------------------------------------------------
  // Bus decode
  //----------------------------------------------------------------------------

  logic        wr_en;
  logic [5:0]  widx;
  logic [NUM_CH-1:0] tick;
  logic [3:0]  slot [NUM_CH];

  // Write takes effect on the request cycle before ack rises
  assign wr_en = ce_i && wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign widx  = wb_adr_i[7:2];
  assign tick  = {vt_tick_i, e1_tick_i, second_ds3_channel_tick_i, ds3a_tick_i, ds2_tick_i, ds1_tick_i};
  assign slot[CH_DS1]  = ds1_slot_i;
  assign slot[CH_DS2]  = ds2_slot_i;
  assign slot[CH_DS3A] = ds3a_slot_i;
  assign slot[CH_SECOND_DS3_CHANNEL] = second_ds3_channel_slot_i;
  assign slot[CH_E1]   = e1_slot_i;
  assign slot[CH_VT]   = vt_slot_i;

  //----------------------------------------------------------------------------
  // Per-channel injectors
  //----------------------------------------------------------------------------

  logic [3:0]  type_r    [NUM_CH];
  logic [3:0]  rate_r    [NUM_CH];
  logic [29:0] cnt_r     [NUM_CH];
  logic [3:0]  consec_r  [NUM_CH];
  logic [NUM_CH-1:0] pend_r;
  logic [NUM_CH-1:0] err_r;
  logic [NUM_CH-1:0] cfg_wr;
  logic [NUM_CH-1:0] fire;
  logic [NUM_CH-1:0] hit;

  // Each channel is an independent engine; the two DS3 copies share no state
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    logic allowed;
    assign cfg_wr[c] = wr_en && (widx == IDX_CFG0 + 6'(c))
                       && type_ok(c, wb_dat_i[7:4]) && rate_ok(wb_dat_i[7:4], wb_dat_i[3:0]);
    // DS2 errors only exist when DS3 carries multiplexed DS1 sub-channels
    assign allowed = (c != CH_DS2) || ds3_muxed_i;
    assign hit[c]  = is_steady(rate_r[c]) && (cnt_r[c] == rate_period(rate_r[c]));
    always_comb begin
      fire[c] = 1'b0;
      if (tick[c] && allowed && slot_match(type_r[c], slot[c])) begin
        unique case (rate_r[c])
          RT_SINGLE: fire[c] = pend_r[c];
          RT_BURST:  fire[c] = burst_i;
          RT_CONT:   fire[c] = 1'b1;
          default:   fire[c] = (is_steady(rate_r[c]) && pend_r[c])
                               || ((rate_r[c] >= RT_CONS7) && (consec_r[c] != 4'h0));
        endcase
      end
    end

    // Configuration; illegal type or rate combinations are ignored
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        type_r[c] <= ET_LOGIC;
        rate_r[c] <= RT_OFF;
      end else if (ce_i && cfg_wr[c]) begin
        type_r[c] <= wb_dat_i[7:4];
        rate_r[c] <= wb_dat_i[3:0];
      end
    end

    // Bit counter for steady rates; counts every transmitted bit
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        cnt_r[c] <= 30'h0;
      end else if (ce_i) begin
        if (cfg_wr[c] || (hit[c] && tick[c])) begin
          cnt_r[c] <= 30'h0;
        end else if (tick[c] && is_steady(rate_r[c])) begin
          cnt_r[c] <= cnt_r[c] + 30'h1;
        end
      end
    end

    // Pending error: armed by a single request or a rate hit, a new arm beats the clear
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        pend_r[c] <= 1'b0;
      end else if (ce_i) begin
        if (cfg_wr[c]) begin
          pend_r[c] <= (wb_dat_i[3:0] == RT_SINGLE);
        end else if (hit[c] && tick[c]) begin
          pend_r[c] <= 1'b1;
        end else if (fire[c]) begin
          pend_r[c] <= 1'b0;
        end
      end
    end

    // Consecutive pointer superframes left
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        consec_r[c] <= 4'h0;
      end else if (ce_i) begin
        if (cfg_wr[c]) begin
          consec_r[c] <= (wb_dat_i[3:0] >= RT_CONS7 && wb_dat_i[3:0] <= RT_CONS9)
                         ? wb_dat_i[3:0] - RT_CONS7 + 4'h7 : 4'h0;
        end else if (fire[c] && consec_r[c] != 4'h0) begin
          consec_r[c] <= consec_r[c] - 4'h1;
        end
      end
    end

    // Error strobe registered toward the framer, one cycle after the tick
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        err_r[c] <= 1'b0;
      end else if (ce_i) begin
        err_r[c] <= fire[c];
      end
    end
  end

  assign ds1_err_o       = err_r[CH_DS1];
  assign ds2_err_o       = err_r[CH_DS2];
  assign ds3a_err_o      = err_r[CH_DS3A];
  assign second_ds3_channel_err_o      = err_r[CH_SECOND_DS3_CHANNEL];
  assign e1_err_o        = err_r[CH_E1];
  assign vt_err_o        = err_r[CH_VT];
  // Type tells the framer where to apply: pre-CRC for data, post-CRC for data-and-check
  assign ds1_err_type_o  = type_r[CH_DS1];
  assign ds2_err_type_o  = type_r[CH_DS2];
  assign ds3a_err_type_o = type_r[CH_DS3A];
  assign second_ds3_channel_err_type_o = type_r[CH_SECOND_DS3_CHANNEL];
  assign e1_err_type_o   = type_r[CH_E1];
  assign vt_err_type_o   = type_r[CH_VT];

  //----------------------------------------------------------------------------
  // Loop codes
  //----------------------------------------------------------------------------

  logic [11:0] code_r [4];
  logic [5:0]  ob_up_r;
  logic [5:0]  ob_dn_r;
  logic [3:0]  up_dur_r;
  logic [3:0]  dn_dur_r;
  logic        up_send_r;
  logic        dn_send_r;
  logic [31:0] sec_cnt_r;
  logic [4:0]  secs_left_r;
  logic        sec_tick;
  logic        loop_wr;
  logic        loop_done;

  assign loop_wr  = wr_en && (widx == IDX_LOOP);
  assign sec_tick = (sec_cnt_r == 32'(SECOND_CYCLES - 1));

  // Programmable code registers; in-band width is carried with the pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) begin
        code_r[i] <= {INBAND_LEN_RST, INBAND_PAT_RST};
      end
      ob_up_r <= OUTBAND_RST;
      ob_dn_r <= OUTBAND_RST;
    end else if (ce_i && wr_en) begin
      if (widx >= IDX_TX_UP && widx <= IDX_RX_DN) begin
        code_r[2'(widx - IDX_TX_UP)] <= wb_dat_i[11:0];
      end
      if (widx == IDX_OB_UP) begin
        ob_up_r <= wb_dat_i[5:0];
      end
      if (widx == IDX_OB_DN) begin
        ob_dn_r <= wb_dat_i[5:0];
      end
    end
  end

  assign tx_up_code_o      = code_r[0];
  assign tx_dn_code_o      = code_r[1];
  assign rx_up_code_o      = code_r[2];
  assign rx_dn_code_o      = code_r[3];
  assign outband_up_code_o = ob_up_r;
  assign outband_dn_code_o = ob_dn_r;

  // Fixed durations end on the seconds count; until-detected ends on the receive match
  always_comb begin
    loop_done = 1'b0;
    if (up_send_r) begin
      loop_done = ((up_dur_r <= LD_16S) && sec_tick && secs_left_r == 5'h1)
                  || ((up_dur_r == LD_UNTIL) && loop_up_detected_i);
    end else if (dn_send_r) begin
      loop_done = ((dn_dur_r <= LD_16S) && sec_tick && secs_left_r == 5'h1)
                  || ((dn_dur_r == LD_UNTIL) && loop_down_detected_i);
    end
  end

  // One code at a time; loop-up wins if both are requested in one write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_dur_r    <= LD_OFF;
      dn_dur_r    <= LD_OFF;
      up_send_r   <= 1'b0;
      dn_send_r   <= 1'b0;
      secs_left_r <= 5'h0;
    end else if (ce_i) begin
      if (loop_wr && wb_dat_i[3:0] <= LD_UNTIL && wb_dat_i[7:4] <= LD_UNTIL) begin
        up_dur_r    <= wb_dat_i[3:0];
        dn_dur_r    <= wb_dat_i[7:4];
        up_send_r   <= (wb_dat_i[3:0] != LD_OFF);
        dn_send_r   <= (wb_dat_i[3:0] == LD_OFF) && (wb_dat_i[7:4] != LD_OFF);
        secs_left_r <= 5'h1 << ((wb_dat_i[3:0] != LD_OFF) ? wb_dat_i[3:0] - LD_1S
                                                          : wb_dat_i[7:4] - LD_1S);
      end else if (loop_done) begin
        up_send_r <= 1'b0;
        dn_send_r <= 1'b0;
      end else if (sec_tick && secs_left_r != 5'h0) begin
        secs_left_r <= secs_left_r - 5'h1;
      end
    end
  end

  // Second prescaler restarts with each loop request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sec_cnt_r <= 32'h0;
    end else if (ce_i) begin
      if (loop_wr || sec_tick || !(up_send_r || dn_send_r)) begin
        sec_cnt_r <= 32'h0;
      end else begin
        sec_cnt_r <= sec_cnt_r + 32'h1;
      end
    end
  end

  assign loop_activate_code_send_o = up_send_r;
  assign loop_release_code_send_o  = dn_send_r;

  //----------------------------------------------------------------------------
  // Read back and acknowledge
  //----------------------------------------------------------------------------

  logic [31:0] rd_nxt;

  // Unmapped words read as zero; status bits show pending and sending state
  always_comb begin
    rd_nxt = 32'h0;
    if (widx < IDX_LOOP) begin
      rd_nxt = {22'h0, err_r[widx[2:0]], pend_r[widx[2:0]],
                type_r[widx[2:0]], rate_r[widx[2:0]]};
    end else if (widx == IDX_LOOP) begin
      rd_nxt = {22'h0, dn_send_r, up_send_r, dn_dur_r, up_dur_r};
    end else if (widx <= IDX_RX_DN) begin
      rd_nxt = {20'h0, code_r[2'(widx - IDX_TX_UP)]};
    end else if (widx == IDX_OB_UP) begin
      rd_nxt = {26'h0, ob_up_r};
    end else if (widx == IDX_OB_DN) begin
      rd_nxt = {26'h0, ob_dn_r};
    end
  end

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce_i) begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) ? rd_nxt : 32'h0;
    end
  end

endmodule : tdm_error_injector

// [tdm_error_injector_pkg.sv]
// Constants, encodings and register map for the tributary error injector
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package tdm_error_injector_pkg;

  // Channel indices
  localparam int NUM_CH  = 6;
  localparam int CH_DS1  = 0;
  localparam int CH_DS2  = 1;
  localparam int CH_DS3A = 2;
  localparam int CH_SECOND_DS3_CHANNEL = 3;
  localparam int CH_E1   = 4;
  localparam int CH_VT   = 5;

  // Error types (4-bit field)
  localparam logic [3:0] ET_LOGIC        = 4'h0;
  localparam logic [3:0] ET_BPV          = 4'h1;
  localparam logic [3:0] ET_DATA         = 4'h2;
  localparam logic [3:0] ET_DATA_CHECK   = 4'h3;
  localparam logic [3:0] ET_FRAME        = 4'h4;
  localparam logic [3:0] ET_PARITY       = 4'h5;
  localparam logic [3:0] ET_C1           = 4'h6;
  localparam logic [3:0] ET_C2           = 4'h7;
  localparam logic [3:0] ET_C3           = 4'h8;
  localparam logic [3:0] ET_C_ALL        = 4'h9;
  localparam logic [3:0] ET_FRAME_CHECK  = 4'hA;
  localparam logic [3:0] ET_MFRAME_CHECK = 4'hB;
  localparam logic [3:0] ET_REI          = 4'hC;
  localparam logic [3:0] ET_FEBE         = 4'hD;
  localparam logic [3:0] ET_POINTER      = 4'hE;

  // Rates (4-bit field); 1E-2..1E-9 are consecutive codes
  localparam logic [3:0] RT_OFF    = 4'h0;
  localparam logic [3:0] RT_SINGLE = 4'h1;
  localparam logic [3:0] RT_BURST  = 4'h2;
  localparam logic [3:0] RT_E2     = 4'h3;
  localparam logic [3:0] RT_E4     = 4'h5;
  localparam logic [3:0] RT_E8     = 4'h9;
  localparam logic [3:0] RT_E9     = 4'hA;
  localparam logic [3:0] RT_CONS7  = 4'hB;
  localparam logic [3:0] RT_CONS9  = 4'hD;
  localparam logic [3:0] RT_CONT   = 4'hE;

  // Bits between steady-rate errors minus one, indexed from the 1E-2 code
  localparam logic [29:0] RATE_PERIOD [8] = '{30'h0000063, 30'h00003E7, 30'h000270F,
    30'h001869F, 30'h00F423F, 30'h098967F, 30'h5F5E0FF, 30'h3B9AC9FF};

  // Slot class presented by the framer with each bit tick
  localparam logic [3:0] SL_PAYLOAD = 4'h0;
  localparam logic [3:0] SL_FRAME   = 4'h1;
  localparam logic [3:0] SL_C1      = 4'h2;
  localparam logic [3:0] SL_C2      = 4'h3;
  localparam logic [3:0] SL_C3      = 4'h4;
  localparam logic [3:0] SL_PARITY  = 4'h5;
  localparam logic [3:0] SL_MFRAME  = 4'h6;
  localparam logic [3:0] SL_CHECK   = 4'h7;
  localparam logic [3:0] SL_POINTER = 4'h8;

  // Loop-code durations (4-bit field)
  localparam logic [3:0] LD_OFF   = 4'h0;
  localparam logic [3:0] LD_1S    = 4'h1;
  localparam logic [3:0] LD_16S   = 4'h5;
  localparam logic [3:0] LD_CONT  = 4'h6;
  localparam logic [3:0] LD_UNTIL = 4'h7;

  // Register byte offsets (word index in bits 7:2)
  localparam logic [5:0] IDX_CFG0      = 6'h00; // 0x00..0x14, one per channel
  localparam logic [5:0] IDX_LOOP      = 6'h06; // 0x18
  localparam logic [5:0] IDX_TX_UP     = 6'h07; // 0x1C
  localparam logic [5:0] IDX_TX_DN     = 6'h08; // 0x20
  localparam logic [5:0] IDX_RX_UP     = 6'h09; // 0x24
  localparam logic [5:0] IDX_RX_DN     = 6'h0A; // 0x28
  localparam logic [5:0] IDX_OB_UP     = 6'h0B; // 0x2C
  localparam logic [5:0] IDX_OB_DN     = 6'h0C; // 0x30

  // Reset values of the loop code registers: pattern in [7:0], length in [11:8]
  localparam logic [7:0] INBAND_PAT_RST = 8'h10;
  localparam logic [3:0] INBAND_LEN_RST = 4'h5;
  localparam logic [5:0] OUTBAND_RST    = 6'h3F;

  // One second at 125 MHz
  localparam int CLK_HZ = 125_000_000;

endpackage : tdm_error_injector_pkg

// [injector_props.sv]
// Port-level assertions for the tributary error injector
`timescale 1ns/100ps
module injector_props
  import tdm_error_injector_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic        ds3_muxed_i,
  input wire logic        ds1_tick_i,
  input wire logic        ds1_err_o,
  input wire logic        ds2_tick_i,
  input wire logic        ds2_err_o,
  input wire logic        ds3a_tick_i,
  input wire logic [3:0]  ds3a_slot_i,
  input wire logic        ds3a_err_o,
  input wire logic [3:0]  ds3a_err_type_o,
  input wire logic        second_ds3_channel_tick_i,
  input wire logic        second_ds3_channel_err_o,
  input wire logic [3:0]  vt_slot_i,
  input wire logic        vt_err_o,
  input wire logic [3:0]  vt_err_type_o,
  input wire logic        loop_activate_code_send_o,
  input wire logic        loop_release_code_send_o
);
  //----------------
  // Checks
  //----------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer one cycle after a fresh request, then drops
  a_ack_follows_req: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data not zero");
  // No error strobe except E1's and no loop code active on the first edge after reset
  a_reset_quiet: assert property ($past(rst_i) |-> !(ds1_err_o || ds2_err_o ||
    ds3a_err_o || second_ds3_channel_err_o || vt_err_o || loop_activate_code_send_o ||
    loop_release_code_send_o)) else $error("active after reset");
  // An error pulse answers a bit tick of the cycle before
  a_ds1_err_tick: assert property (ds1_err_o |-> $past(ds1_tick_i))
    else $error("ds1 err w/o tick");
  a_ds2_needs_mux: assert property (ds2_err_o |-> $past(ds2_tick_i && ds3_muxed_i))
    else $error("ds2 err while not muxed");
  a_second_ds3_channel_err_tick: assert property (second_ds3_channel_err_o |-> $past(second_ds3_channel_tick_i))
    else $error("second_ds3_channel err");
  a_ds3_frame_slot: assert property (ds3a_err_o && ds3a_err_type_o == ET_FRAME |->
    $past(ds3a_tick_i) && $past(ds3a_slot_i) == SL_FRAME) else $error("ds3 frame slot");
  a_vt_pointer_slot: assert property (vt_err_o && vt_err_type_o == ET_POINTER |->
    $past(vt_slot_i) == SL_POINTER) else $error("vt pointer slot");
  a_loop_exclusive: assert property (
    !(loop_activate_code_send_o && loop_release_code_send_o))
    else $error("both loop codes sent");
endmodule : injector_props

bind tdm_error_injector injector_props props_u (.*);

// [framer_model.sv]
// Framer stand-in: bit ticks out, error pulses counted per channel
`timescale 1ns/100ps
module framer_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic        clr_i,
  input  wire logic [5:0]  err_i,
  output logic             tick_o,
  output logic [5:0][15:0] cnt_o
);
  // Tick follows run so burst level lines up with the same bit
  assign tick_o = run_i;
  // One pulse is one corrupted bit
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 6; c++) begin
      cnt_o[c] <= clr_i ? 16'h0000 : cnt_o[c] + {15'h0000, err_i[c]};
    end
  end
endmodule : framer_model

// [tb_top.sv]
// Self-checking bench for the tributary error injector
`timescale 1ns/100ps
module tb_top;
  import tdm_error_injector_pkg::*;
  localparam int SEC = 20; // Short second keeps loop-code runs brief
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_we_i = 1'b0, burst_i = 1'b0;
  logic ds3_muxed_i = 1'b1, loop_up_detected_i = 1'b0, loop_down_detected_i = 1'b0;
  logic run = 1'b0, clr = 1'b0;
  logic tick, wb_ack_o, loop_activate_code_send_o, loop_release_code_send_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] slot = 4'h0, ds1_err_type_o, ds2_err_type_o, ds3a_err_type_o;
  logic [3:0] second_ds3_channel_err_type_o, e1_err_type_o, vt_err_type_o;
  logic [5:0] err, outband_up_code_o, outband_dn_code_o;
  logic [5:0][15:0] cnt;
  logic [5:0][3:0] types;
  assign types = {vt_err_type_o, e1_err_type_o, second_ds3_channel_err_type_o, ds3a_err_type_o,
                  ds2_err_type_o, ds1_err_type_o};
  logic [11:0] tx_up_code_o, tx_dn_code_o, rx_up_code_o, rx_dn_code_o;
  int num_errors = 0, total_checks = 0, exp_b, n;
  // Two passes over the channels; the second reaches five types the first leaves out
  logic [3:0] s_type [12] = '{ET_DATA, ET_C1, ET_FRAME, ET_PARITY, ET_MFRAME_CHECK, ET_FEBE,
    ET_FRAME, ET_C3, ET_C_ALL, ET_BPV, ET_DATA_CHECK, ET_LOGIC};
  logic [3:0] s_slot [12] = '{SL_PAYLOAD, SL_C1, SL_FRAME, SL_PARITY, SL_MFRAME, SL_CHECK,
    SL_FRAME, SL_C3, SL_C3, SL_MFRAME, SL_PAYLOAD, SL_PAYLOAD};
  always #4 clk_i = ~clk_i;
  tdm_error_injector #(.SECOND_CYCLES(SEC)) dut_u (.*, .ce_i(1'b1), .wb_stb_i(wb_cyc_i),
    .wb_sel_i(4'hF), .ds1_tick_i(tick), .ds1_slot_i(slot),
    .ds2_tick_i(tick), .ds2_slot_i(slot), .ds3a_tick_i(tick), .ds3a_slot_i(slot),
    .second_ds3_channel_tick_i(tick), .second_ds3_channel_slot_i(slot), .e1_tick_i(tick), .e1_slot_i(slot), .vt_tick_i(tick),
    .vt_slot_i(slot), .ds1_err_o(err[0]), .ds2_err_o(err[1]), .ds3a_err_o(err[2]),
    .second_ds3_channel_err_o(err[3]), .e1_err_o(err[4]), .vt_err_o(err[5]));
  framer_model fm_u (.clk_i(clk_i), .run_i(run), .clr_i(clr), .err_i(err), .tick_o(tick),
    .cnt_o(cnt));
  // Expected values from the settings
  function automatic logic [31:0] cfg(input logic [3:0] t, input logic [3:0] r);
    return {24'h0, t, r};
  endfunction : cfg
  function automatic logic [31:0] exp_steady(input int nt, input int p);
    return (nt > p) ? 32'h1 : 32'h0; // First error lands on tick p+1
  endfunction : exp_steady
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // Classic single cycle; waits for ack under a bound
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    if (k >= 20) begin
      chk(32'h0, 32'h1, "bus timeout");
      print_verdict();
    end
  endtask : wb
  // Run nt ticks of one slot class; bm 0 no burst, 1 random, 2 always
  task automatic ticks(input int nt, input logic [3:0] s, input int bm);
    logic b;
    exp_b = 0;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    slot <= s;
    repeat (nt) begin
      b = (bm == 2) || (bm == 1 && $urandom_range(1) == 1);
      burst_i <= b;
      run <= 1'b1;
      exp_b += b;
      @(posedge clk_i);
    end
    run <= 1'b0;
    burst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : ticks
  initial begin
    void'($urandom(88988));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h1C, 32'h0);
    chk({20'h0, rd[11:0]}, 32'h510, "tx up code");
    chk({20'h0, rx_dn_code_o}, 32'h510, "rx dn port");
    wb(1'b0, 8'h2C, 32'h0);
    chk({26'h0, rd[5:0]}, 32'h3F, "outband code");
    wb(1'b0, 8'h00, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h0, "cfg after reset");
    wb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    $display("test defaults done");
    // One single error per channel on its own slot class
    for (int c = 0; c < 12; c++) begin
      wb(1'b1, 8'((c % 6) * 4), cfg(s_type[c], RT_SINGLE));
      ticks(5, s_slot[c], 0);
      chk({28'h0, types[c % 6]}, {28'h0, s_type[c]}, "type out");
      for (int k = 0; k < 6; k++) chk({16'h0, cnt[k]}, 32'(k == c % 6), "single");
    end
    $display("test singles done");
    wb(1'b1, 8'h08, cfg(ET_DATA, RT_E2));
    ticks(150, SL_PAYLOAD, 0);
    chk({16'h0, cnt[2]}, exp_steady(150, 100), "steady 1E-2");
    wb(1'b1, 8'h0C, cfg(ET_DATA, RT_BURST));
    ticks(40, SL_PAYLOAD, 1);
    chk({16'h0, cnt[3]}, 32'(exp_b), "burst second_ds3_channel");
    ds3_muxed_i <= 1'b0;
    wb(1'b1, 8'h04, cfg(ET_C_ALL, RT_BURST));
    ticks(10, SL_C2, 2);
    chk({16'h0, cnt[1]}, 32'h0, "ds2 unmuxed");
    ds3_muxed_i <= 1'b1;
    ticks(10, SL_C2, 2);
    chk({16'h0, cnt[1]}, 32'hA, "ds2 c-all");
    wb(1'b1, 8'h14, cfg(ET_POINTER, RT_CONS7));
    ticks(12, SL_POINTER, 0);
    chk({16'h0, cnt[5]}, 32'h7, "pointer x7");
    wb(1'b1, 8'h14, cfg(ET_REI, RT_E8));
    wb(1'b0, 8'h14, 32'h0);
    chk({24'h0, rd[7:0]}, cfg(ET_POINTER, RT_CONS7), "rei rate refused");
    $display("test rates done");
    wb(1'b1, 8'h18, 32'h01);
    @(posedge clk_i);
    chk({31'h0, loop_activate_code_send_o}, 32'h1, "loop up start");
    n = 0;
    while (loop_activate_code_send_o === 1'b1 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(n >= SEC - 2 && n <= SEC + 1), 32'h1, "loop up 1s");
    wb(1'b1, 8'h18, 32'h70);
    @(posedge clk_i);
    chk({31'h0, loop_release_code_send_o}, 32'h1, "loop down start");
    loop_down_detected_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, loop_release_code_send_o}, 32'h0, "loop down until");
    loop_down_detected_i <= 1'b0;
    wb(1'b1, 8'h18, 32'h07);
    @(posedge clk_i);
    chk({31'h0, loop_activate_code_send_o}, 32'h1, "loop up until start");
    loop_up_detected_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, loop_activate_code_send_o}, 32'h0, "loop up until");
    loop_up_detected_i <= 1'b0;
    wb(1'b1, 8'h18, 32'h06);
    repeat (2 * SEC) @(posedge clk_i);
    chk({31'h0, loop_activate_code_send_o}, 32'h1, "loop up continuous");
    $display("test loop codes done");
    // Reset in mid-run must stop a continuous code and clear the settings
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk({31'h0, loop_activate_code_send_o}, 32'h0, "send after reset");
    wb(1'b0, 8'h14, 32'h0);
    chk({24'h0, rd[7:0]}, 32'h0, "vt cfg after reset");
    $display("test reset done");
    print_verdict();
  end
endmodule : tb_top
